// file: pkg/adc_seq_pkg.sv
package adc_seq_pkg;

	// ==========================================================
	// Serial word layout
	localparam int WORD_BITS = 32;
	localparam int CFG_BITS = 13;
	localparam logic [5:0] WORD_LAST = 6'h20;
	localparam logic [5:0] CFG_DONE_RISE = 6'h0D;
	localparam logic [5:0] MUX_SWITCH_FALL = 6'h0E;
	localparam logic [2:0] CMD_UPDATE = 3'h5;
	localparam logic [4:0] SPEED_KEEP = 5'h00;
	localparam int SAMPLE_W = 24;
	localparam int RESULT_W = 25;
	localparam logic [4:0] WORD_PAD = 5'h00;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_EOCTEST_NS = 500;
	localparam int EOCTEST_CYC_I = T_EOCTEST_NS / CLK_PERIOD_NS;
	localparam logic [7:0] EOCTEST_CYC = EOCTEST_CYC_I[7:0];
	localparam logic [7:0] SCK_HALF_CYC = 8'h04;

	// ==========================================================
	// Types
	typedef struct packed {
		logic single_ended_select;
		logic odd_select;
		logic channel_index_bit2;
		logic channel_index_bit1;
		logic channel_index_bit0;
	} chan_t;

	typedef struct packed {
		logic [3:0] oversampling_code;
		logic rate_double_select;
	} speed_t;

	typedef struct packed {
		chan_t chan;
		speed_t speed;
	} cfg_t;

	// Differential 0/1, ratio 256, single rate
	localparam cfg_t CFG_RESET = '{chan: 5'h00, speed: 5'h06};

	typedef enum logic [2:0] {
		ST_CONV = 3'h1,
		ST_SLEEP = 3'h2,
		ST_DATA = 3'h4
	} seq_state_t;

endpackage

// file: hw/adc_serial_conversion_control.sv
`timescale 1ns/1ps
module adc_serial_conversion_control
	import adc_seq_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// Serial pins
	input wire logic i_cs_n,
	input wire logic i_sdi,
	input wire logic i_sck,
	output logic o_sck,
	output logic o_sck_oe_n,
	output logic o_sdo,
	output logic o_sdo_oe_n,
	output logic o_busy,
	input wire logic i_clock_source_select,
	// Modulator interface
	output logic o_conv_start,
	output logic o_conv_chop,
	input wire logic i_conv_done,
	input wire logic [SAMPLE_W-1:0] i_conv_sample,
	// Active settings
	output chan_t o_mux,
	output speed_t o_speed,
	output logic o_result_valid,
	output logic o_sleep
);

	// ==========================================================
	// State
	typedef struct packed {
		seq_state_t state;
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic sck_s1;
		logic sck_s2;
		logic sck_s3;
		logic sdi_s1;
		logic sdi_s2;
		logic ext_s1;
		logic ext_s2;
		cfg_t cfg;
		chan_t mux;
		chan_t prev_mux;
		speed_t run;
		logic launch;
		logic conv_start;
		logic chop;
		logic step;
		logic prev_ok;
		logic [SAMPLE_W-1:0] samp0;
		logic [SAMPLE_W-1:0] prev_samp;
		logic [WORD_BITS-1:0] shreg;
		logic [CFG_BITS-1:0] shin;
		logic [5:0] rise_cnt;
		logic [5:0] fall_cnt;
		logic [7:0] div;
		logic [7:0] wait_cnt;
		logic sck;
		logic sck_oe_n;
		logic sdo;
		logic sdo_oe_n;
		logic busy;
		logic valid;
	} reg_t;

	reg_t q;
	reg_t d;

	// ==========================================================
	// Functions
	// Chopped pair: offset cancels, half the difference is the signal
	function automatic logic [RESULT_W-1:0] combine(
		input logic [SAMPLE_W-1:0] pos,
		input logic [SAMPLE_W-1:0] neg
	);
		logic [RESULT_W:0] diff;
		diff = {pos[SAMPLE_W-1], pos[SAMPLE_W-1], pos}
			- {neg[SAMPLE_W-1], neg[SAMPLE_W-1], neg};
		return diff[RESULT_W:1];
	endfunction

	function automatic cfg_t commit(
		input cfg_t cur,
		input logic [CFG_BITS-1:0] w
	);
		cfg_t c;
		c = cur;
		if (w[12:10] == CMD_UPDATE) begin
			c.chan = chan_t'(w[9:5]);
			if (w[4:0] != SPEED_KEEP) begin
				c.speed = speed_t'(w[4:0]);
			end
		end
		return c;
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		logic int_mode;
		logic rise;
		logic fall;
		logic cs_rise;
		logic start;
		logic finish;
		logic [RESULT_W-1:0] res;
		cfg_t ncfg;
		int_mode = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		cs_rise = 1'b0;
		start = 1'b0;
		finish = 1'b0;
		res = '0;
		ncfg = q.cfg;
		d = q;
		d.conv_start = 1'b0;
		d.cs_s1 = i_cs_n;
		d.cs_s2 = q.cs_s1;
		d.cs_s3 = q.cs_s2;
		d.sck_s1 = i_sck;
		d.sck_s2 = q.sck_s1;
		d.sck_s3 = q.sck_s2;
		d.sdi_s1 = i_sdi;
		d.sdi_s2 = q.sdi_s1;
		d.ext_s1 = i_clock_source_select;
		d.ext_s2 = q.ext_s1;
		int_mode = q.ext_s2;
		d.sck_oe_n = ~int_mode;
		d.sdo_oe_n = q.cs_s2;
		cs_rise = q.cs_s2 & ~q.cs_s3;
		if (!int_mode) begin
			rise = q.sck_s2 & ~q.sck_s3;
			fall = ~q.sck_s2 & q.sck_s3;
		end

		case (q.state)
			ST_CONV: begin
				if (q.launch) begin
					d.launch = 1'b0;
					d.conv_start = 1'b1;
				end else if (i_conv_done) begin
					if (!q.run.rate_double_select) begin
						if (!q.step) begin
							d.samp0 = i_conv_sample;
							d.step = 1'b1;
							d.chop = 1'b1;
							d.launch = 1'b1;
						end else begin
							res = combine(q.samp0, i_conv_sample);
							d.valid = 1'b1;
							// Keep the second half so a later double
							// rate average starts from a valid pair
							d.prev_samp = i_conv_sample;
							d.prev_mux = q.mux;
							d.prev_ok = 1'b1;
							d.chop = 1'b0;
							finish = 1'b1;
						end
					end else begin
						if (q.chop) begin
							res = combine(q.prev_samp, i_conv_sample);
						end else begin
							res = combine(i_conv_sample, q.prev_samp);
						end
						// Pair spans two channels after a switch
						d.valid = q.prev_ok && (q.prev_mux == q.mux);
						d.prev_samp = i_conv_sample;
						d.prev_mux = q.mux;
						d.prev_ok = 1'b1;
						d.chop = ~q.chop;
						d.mux = q.cfg.chan;
						finish = 1'b1;
					end
				end
				if (finish) begin
					d.shreg = {2'b00, res, WORD_PAD};
					d.busy = 1'b0;
					d.sdo = 1'b0;
					d.state = ST_SLEEP;
					d.wait_cnt = '0;
					if (int_mode) begin
						d.sck = 1'b0;
					end
				end
			end
			ST_SLEEP: begin
				if (int_mode) begin
					d.sck = 1'b0;
					if (q.cs_s2) begin
						d.wait_cnt = '0;
					end else if (q.wait_cnt == EOCTEST_CYC - 8'h01) begin
						rise = 1'b1;
					end else begin
						d.wait_cnt = q.wait_cnt + 8'h01;
					end
				end
				if (rise && !q.cs_s2) begin
					d.state = ST_DATA;
					d.rise_cnt = 6'h01;
					d.fall_cnt = '0;
					d.div = '0;
					d.shin = {q.shin[CFG_BITS-2:0], q.sdi_s2};
					if (int_mode) begin
						d.sck = 1'b1;
					end
				end
			end
			ST_DATA: begin
				if (int_mode) begin
					if (q.div == SCK_HALF_CYC - 8'h01) begin
						d.div = '0;
						d.sck = ~q.sck;
						rise = ~q.sck;
						fall = q.sck;
					end else begin
						d.div = q.div + 8'h01;
					end
				end
				if (cs_rise) begin
					if (q.rise_cnt >= CFG_DONE_RISE
						&& q.fall_cnt < MUX_SWITCH_FALL) begin
						ncfg = commit(q.cfg, q.shin);
					end
					start = 1'b1;
				end else if (rise) begin
					d.rise_cnt = q.rise_cnt + 6'h01;
					if (q.rise_cnt < CFG_DONE_RISE) begin
						d.shin = {q.shin[CFG_BITS-2:0], q.sdi_s2};
					end
					// Internal clock ends on its last rising edge
					if (int_mode && q.rise_cnt == WORD_LAST - 6'h01) begin
						start = 1'b1;
					end
				end else if (fall) begin
					d.fall_cnt = q.fall_cnt + 6'h01;
					d.shreg = {q.shreg[WORD_BITS-2:0], 1'b0};
					d.sdo = q.shreg[WORD_BITS-2];
					if (q.fall_cnt == MUX_SWITCH_FALL - 6'h01
						&& q.rise_cnt >= CFG_DONE_RISE) begin
						ncfg = commit(q.cfg, q.shin);
						if (!q.run.rate_double_select) begin
							d.mux = ncfg.chan;
						end
					end
					if (q.fall_cnt == WORD_LAST - 6'h01) begin
						start = 1'b1;
					end
				end
				d.cfg = ncfg;
				if (start) begin
					d.state = ST_CONV;
					d.busy = 1'b1;
					d.sdo = 1'b1;
					d.sck = 1'b1;
					d.launch = 1'b1;
					d.step = 1'b0;
					d.run = ncfg.speed;
					if (!ncfg.speed.rate_double_select) begin
						// Single rate always starts a fresh chopped pair
						d.chop = 1'b0;
						d.mux = ncfg.chan;
					end
				end
			end
			default: begin
				d.state = ST_CONV;
				d.launch = 1'b1;
				d.busy = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			q <= '0;
			q.state <= ST_CONV;
			q.cfg <= CFG_RESET;
			q.run <= CFG_RESET.speed;
			q.launch <= 1'b1;
			q.busy <= 1'b1;
			q.sdo <= 1'b1;
			q.sck <= 1'b1;
			q.sck_oe_n <= 1'b1;
			q.sdo_oe_n <= 1'b1;
			q.cs_s1 <= 1'b1;
			q.cs_s2 <= 1'b1;
			q.cs_s3 <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	assign o_sck = q.sck;
	assign o_sck_oe_n = q.sck_oe_n;
	assign o_sdo = q.sdo;
	assign o_sdo_oe_n = q.sdo_oe_n;
	assign o_busy = q.busy;
	assign o_conv_start = q.conv_start;
	assign o_conv_chop = q.chop;
	assign o_mux = q.mux;
	assign o_speed = q.run;
	assign o_result_valid = q.valid;
	assign o_sleep = (q.state == ST_SLEEP);

endmodule

// file: testbench/adc_mod_model.sv
`timescale 1ns/1ps
// ==========================================================
// Modulator stand-in: one sample per start, 30 cycles later
module adc_mod_model
	import adc_seq_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_start,
	input wire logic i_chop,
	output logic o_done,
	output logic [SAMPLE_W-1:0] o_sample
);
	int cnt = 0;
	logic ch = 1'b0;
	initial o_done = 1'b0;
	initial o_sample = 24'h000000;
	always @(posedge i_clk_sys) begin
		o_done <= 1'b0;
		// Sample is junk outside the done pulse
		o_sample <= ~o_sample;
		if (i_start) begin
			cnt <= 30;
			ch <= i_chop;
		end else if (cnt == 1) begin
			cnt <= 0;
			o_done <= 1'b1;
			o_sample <= ch ? 24'h000100 : 24'h000400;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// file: testbench/adc_seq_chk.sv
`timescale 1ns/1ps
module adc_seq_chk (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_cs_n,
	input wire logic i_clock_source_select,
	input wire logic i_conv_done,
	input wire logic o_sdo,
	input wire logic o_sdo_oe_n,
	input wire logic o_sck_oe_n,
	input wire logic o_busy,
	input wire logic o_sleep,
	input wire logic o_conv_start
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	sleep_busy_a: assert property (o_sleep |-> !o_busy)
		else $error("busy high in sleep");
	sleep_entry_a: assert property ($rose(o_sleep) |-> $past(i_conv_done))
		else $error("sleep without done");
	busy_fall_a: assert property ($fell(o_busy) |-> o_sleep)
		else $error("busy fell outside sleep");
	sdo_hiz_a: assert property (i_cs_n [*4] |=> o_sdo_oe_n)
		else $error("sdo driven while deselected");
	sdo_sleep_a: assert property (o_sleep && !o_sdo_oe_n |-> !o_sdo)
		else $error("flag high in sleep");
	sdo_conv_a: assert property (o_busy && !o_sdo_oe_n && $past(o_busy, 4)
		|-> o_sdo)
		else $error("flag low while converting");
	start_pulse_a: assert property (o_conv_start |=> !o_conv_start)
		else $error("start longer than one cycle");
	start_busy_a: assert property (o_conv_start |-> o_busy)
		else $error("start without busy");
	ext_sck_a: assert property (!i_clock_source_select [*4] |=> o_sck_oe_n)
		else $error("clock driven in external mode");
	busy_rise_a: assert property ($rose(o_busy) |-> ##[0:4] o_conv_start)
		else $error("busy rose without start");
endmodule
bind adc_serial_conversion_control adc_seq_chk adc_seq_chk_i (.i_clk_sys,
	.i_sys_rst, .i_cs_n, .i_clock_source_select, .i_conv_done, .o_sdo,
	.o_sdo_oe_n, .o_sck_oe_n, .o_busy, .o_sleep, .o_conv_start);

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import adc_seq_pkg::*;
	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cs_n = 1'b1;
	logic sdi = 1'b0;
	logic sck_d = 1'b0;
	logic csel = 1'b0;
	logic sck_o, sck_oe_n, sdo, sdo_oe_n, busy, start, chop, done, valid, slp;
	logic [SAMPLE_W-1:0] smp;
	chan_t mux, m14, m15;
	speed_t spd;
	logic [31:0] w;
	int fails = 0;
	int n_tests = 0;
	int ncyc = 0;
	// Device drives the clock pin only when its enable is low
	wire sck_pin = sck_oe_n ? sck_d : sck_o;
	always #5 clk = ~clk;
	adc_serial_conversion_control adc_serial_conversion_control_i (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_cs_n(cs_n), .i_sdi(sdi),
		.i_sck(sck_pin), .o_sck(sck_o), .o_sck_oe_n(sck_oe_n), .o_sdo(sdo),
		.o_sdo_oe_n(sdo_oe_n), .o_busy(busy), .i_clock_source_select(csel),
		.o_conv_start(start), .o_conv_chop(chop), .i_conv_done(done),
		.i_conv_sample(smp), .o_mux(mux), .o_speed(spd),
		.o_result_valid(valid), .o_sleep(slp));
	adc_mod_model adc_mod_model_i (.i_clk_sys(clk), .i_start(start),
		.i_chop(chop), .o_done(done), .o_sample(smp));
	// ==========================================================
	// Helpers
	task automatic give_verdict;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_sleep;
		int k;
		k = 0;
		while (slp !== 1'b1 && k < 3000) begin
			cyc(1);
			k++;
		end
		chk("sleep", 1, slp);
	endtask
	// Low phase 5 cycles, high 3: 80 ns, data settled before each rise
	task automatic spi(input logic [12:0] c, input int n);
		wait_sleep;
		cs_n = 1'b0;
		cyc(10);
		for (int k = 1; k <= n; k++) begin
			sdi = (k <= 13) ? c[13-k] : 1'b0;
			cyc(5);
			w[32-k] = sdo;
			if (k == 14) m14 = mux;
			if (k == 15) m15 = mux;
			if (k == 16) chk("busy_data", 0, busy);
			sck_d = 1'b1;
			cyc(3);
			sck_d = 1'b0;
		end
		cyc(6);
		cs_n = 1'b1;
		cyc(6);
		chk("busy_after", 1, busy);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_prog;
		chk("mux_rst", 0, mux);
		chk("spd_rst", 5'h06, spd);
		spi({3'h5, 5'h1B, 5'h08}, 32);
		chk("flag", 0, w[31]);
		chk("result", 25'h000180, w[29:5]);
		chk("pad", 0, w[4:0]);
		chk("mux_f13", 0, m14);
		chk("mux_f14", 5'h1B, m15);
		chk("spd", 5'h08, spd);
		$display("t_prog done");
	endtask
	task automatic t_abort;
		spi({3'h5, 5'h05, 5'h0A}, 10);
		chk("mux_abort", 5'h1B, mux);
		chk("spd_abort", 5'h08, spd);
		spi({3'h0, 5'h05, 5'h0A}, 32);
		chk("mux_keep", 5'h1B, mux);
		spi({3'h5, 5'h07, 5'h00}, 32);
		chk("mux_new", 5'h07, mux);
		chk("spd_keep", 5'h08, spd);
		$display("t_abort done");
	endtask
	task automatic t_rate_double_select;
		spi({3'h5, 5'h07, 5'h09}, 32);
		chk("spd_2x", 5'h09, spd);
		wait_sleep;
		chk("valid_rate", 1, valid);
		spi({3'h5, 5'h02, 5'h00}, 32);
		chk("result_2x", 25'h000180, w[29:5]);
		chk("mux_hold", 5'h07, m15);
		wait_sleep;
		chk("mux_end", 5'h02, mux);
		spi(13'h0000, 32);
		wait_sleep;
		chk("valid_first", 0, valid);
		spi(13'h0000, 32);
		wait_sleep;
		chk("valid_next", 1, valid);
		$display("t_rate_double_select done");
	endtask
	task automatic t_int;
		int k, n;
		logic p;
		k = 0;
		n = 0;
		p = 1'b0;
		csel = 1'b1;
		cs_n = 1'b0;
		while (busy !== 1'b1 && k < 3000) begin
			cyc(1);
			k++;
			if (k == 100) chk("sck_oe", 0, sck_oe_n);
			if (sck_pin && !p) n++;
			p = sck_pin;
		end
		chk("sck_count", 32, n);
		cs_n = 1'b1;
		csel = 1'b0;
		$display("t_int done");
	endtask
	// ==========================================================
	// Main sequence and watchdog
	always @(negedge clk) begin
		ncyc++;
		if (ncyc == 30000) begin
			fails++;
			give_verdict;
		end
	end
	initial begin
		cyc(20);
		rst = 1'b0;
		cyc(1);
		chk("busy_rst", 1, busy);
		t_prog;
		t_abort;
		t_rate_double_select;
		t_int;
		give_verdict;
	end
endmodule
